// [core/cmc_pkg.sv]
package cmc_pkg;

  // strap decode and control personality
  typedef enum logic [1:0] {
    MODE_TWO_WIRE,
    MODE_PIN_DIFF,
    MODE_PIN_SE,
    MODE_THREE_WIRE
  } cmc_mode_e;

  // strap input encoding from the four-level front end
  localparam logic [1:0] STRAP_TIED_LOW  = 2'h0;
  localparam logic [1:0] STRAP_PULLDOWN  = 2'h1;
  localparam logic [1:0] STRAP_PULLUP    = 2'h2;
  localparam logic [1:0] STRAP_TIED_HIGH = 2'h3;
  localparam logic [1:0] STRAP_SETTLE    = 2'h2;

  // serial word layout
  localparam logic [4:0] FIRST_WORD_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST       = 5'h07;
  localparam int         IDX_MSB         = 14;
  localparam int         IDX_LSB         = 8;

  // mode register indices and reset values
  localparam logic [6:0] REG_SYS_IDX  = 7'h40;
  localparam logic [6:0] REG_ADC_IDX  = 7'h41;
  localparam logic [6:0] REG_DAC_IDX  = 7'h42;
  localparam logic [6:0] REG_ZERO_IDX = 7'h43;
  localparam logic [7:0] REG_SYS_RST  = 8'h00;
  localparam logic [7:0] REG_ADC_RST  = 8'h00;
  localparam logic [7:0] REG_DAC_RST  = 8'h00;
  localparam logic [7:0] REG_ZERO_RST = 8'h00;

  // field positions
  localparam int SYS_SE_BIT     = 0;
  localparam int SYS_DBL_BIT    = 1;
  localparam int IF_MASTER_BIT  = 0;
  localparam int IF_FMT_LSB     = 1;
  localparam int DAC_DEEMPH_BIT = 3;
  localparam int DAC_DSEL_LSB   = 4;
  localparam int ZERO_GROUP_BIT = 0;
  localparam int ZERO_POL_BIT   = 1;

  // audio format and de-emphasis codes
  localparam logic [1:0] FMT_I2S_24  = 2'h0;
  localparam logic [1:0] FMT_LJ_24   = 2'h1;
  localparam logic [1:0] DEEMPH_44K1 = 2'h1;

  // oversampling
  localparam logic [7:0] ADC_OSR       = 8'h40;
  localparam logic [7:0] DAC_OSR_HIGH  = 8'h40;
  localparam logic [7:0] DAC_OSR_MID   = 8'h20;
  localparam logic [7:0] DAC_OSR_LOW   = 8'h10;
  localparam logic [1:0] RATIO_HIGH    = 2'h0;
  localparam logic [1:0] RATIO_MID     = 2'h1;
  localparam logic [1:0] PIN_MASTER_FS = 2'h0;

  // zero detect run length
  localparam logic [10:0] ZERO_RUN = 11'h400;

endpackage

// [core/cmc_spi_shift.sv]
module cmc_spi_shift (
  // link side
  input  wire logic       ctrl_serial_clock,
  input  wire logic       ctrl_select_n,
  input  wire logic       ctrl_serial_data_in,
  // control
  input  wire logic       reset,
  input  wire logic       link_enable,
  // completed word towards the core
  output logic            word_toggle,
  output logic [6:0]      word_index,
  output logic [7:0]      word_data
);

  typedef struct packed {
    logic [4:0]  cnt;
    logic [14:0] shift;
    logic        first;
    logic [6:0]  idx;
  } cmc_frame_s;

  typedef struct packed {
    logic       tog;
    logic [6:0] idx;
    logic [7:0] data;
  } cmc_word_s;

  cmc_frame_s fr_q, fr_d;
  cmc_word_s  wd_q, wd_d;
  logic       frame_rst;
  logic [15:0] sh;

  // select high ends the frame; the clock may stop outside frames
  assign frame_rst = reset | ctrl_select_n | ~link_enable;
  assign sh        = {fr_q.shift, ctrl_serial_data_in};

  always_comb begin
    fr_d = fr_q;
    wd_d = wd_q;
    fr_d.shift = sh[14:0];
    fr_d.cnt   = fr_q.cnt + 5'h01;
    if (fr_q.first && fr_q.cnt == cmc_pkg::FIRST_WORD_LAST) begin
      wd_d.idx   = sh[cmc_pkg::IDX_MSB:cmc_pkg::IDX_LSB];
      wd_d.data  = sh[7:0];
      wd_d.tog   = ~wd_q.tog;
      fr_d.first = 1'b0;
      fr_d.cnt   = 5'h00;
      fr_d.idx   = sh[cmc_pkg::IDX_MSB:cmc_pkg::IDX_LSB] + 7'h01;
    end else if (!fr_q.first && fr_q.cnt == cmc_pkg::BYTE_LAST) begin
      wd_d.idx  = fr_q.idx;
      wd_d.data = sh[7:0];
      wd_d.tog  = ~wd_q.tog;
      fr_d.cnt  = 5'h00;
      fr_d.idx  = fr_q.idx + 7'h01;
    end
  end

  // rising clock edge shifts msb first
  always_ff @(posedge ctrl_serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      fr_q <= '{cnt: 5'h00, shift: 15'h0000, first: 1'b1, idx: 7'h00};
    end else begin
      fr_q <= fr_d;
    end
  end

  // the completed word survives the end of frame
  always_ff @(posedge ctrl_serial_clock or posedge reset) begin
    if (reset) begin
      wd_q <= '{tog: 1'b0, idx: 7'h00, data: 8'h00};
    end else begin
      wd_q <= wd_d;
    end
  end

  assign word_toggle = wd_q.tog;
  assign word_index  = wd_q.idx;
  assign word_data   = wd_q.data;

endmodule // cmc_spi_shift

// [core/cmc_zero_detect.sv]
module cmc_zero_detect (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // samples
  input  wire logic sample_strobe,
  input  wire logic sample_zero,
  // result
  output logic      zero_detected
);

  typedef struct packed {
    logic [10:0] run;
    logic        flag;
  } cmc_zd_s;

  cmc_zd_s q, d;

  always_comb begin
    d = q;
    if (sample_strobe) begin
      if (!sample_zero) begin
        d.run  = 11'h000;
        d.flag = 1'b0;
      end else if (q.run != cmc_pkg::ZERO_RUN) begin
        d.run = q.run + 11'h001;
        if (d.run == cmc_pkg::ZERO_RUN) begin
          d.flag = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{run: 11'h000, flag: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign zero_detected = q.flag;

endmodule // cmc_zero_detect

// [core/cmc_ctrl_port.sv]
// Overview of operation
// - strap decodes to four control personalities
// - strap caught only at reset release
// - three shared pins change role per mode
// - pin mode: role pin picks adc master
// - pin mode: format pin picks i2s or lj
// - pin mode: de-emphasis pin, always 44.1k
// - serial modes use registers, pin mode pins
// - serial port runs on its own clock
// - commit each register when the next word lands or select rises
// - burst appends bytes until select rises
// - 1024 zero samples set channel zero flag
// - grouping bit merges both zero flags
// - polarity bit inverts zero flag level
// - single-ended via strap or register bit
// - adc osr fixed, dac osr from ratio
module cmc_ctrl_port (
  // core clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // strap and shared control pins
  input  wire logic [1:0]        mode_strap,
  input  wire logic              ctrl_serial_clock,
  input  wire logic              ctrl_serial_data_in,
  input  wire logic              ctrl_select_n,
  // dac sample stream and clock ratio
  input  wire logic              dac_sample_strobe,
  input  wire logic              dac_sample_right,
  input  wire logic              dac_sample_zero,
  input  wire logic [1:0]        dac_ratio_class,
  // status
  output cmc_pkg::cmc_mode_e     ctrl_mode,
  output logic                   mode_captured,
  // two-wire pins passed to the two-wire block
  output logic                   twowire_data,
  output logic                   twowire_clock,
  output logic                   twowire_addr_sel,
  // audio configuration
  output logic                   adc_master,
  output logic                   dac_master,
  output logic [1:0]             adc_format,
  output logic [1:0]             dac_format,
  output logic                   deemph_en,
  output logic [1:0]             deemph_sel,
  output logic                   dac_single_ended,
  output logic [7:0]             adc_osr,
  output logic [7:0]             dac_osr,
  // zero flags
  output logic                   left_zero_flag,
  output logic                   right_zero_flag
);

  typedef struct packed {
    logic [1:0]         strap_m;
    logic [1:0]         strap_s;
    logic [2:0]         pin_m;
    logic [2:0]         pin_s;
    logic               tog_m;
    logic               tog_s;
    logic               tog_seen;
    logic [2:0]         sel_dly;
    logic [1:0]         settle;
    logic               captured;
    cmc_pkg::cmc_mode_e mode;
    logic               close;
    logic               pend_v;
    logic [6:0]         pend_idx;
    logic [7:0]         pend_data;
    logic [3:0][7:0]    regs;
    logic               adc_m;
    logic               dac_m;
    logic [1:0]         adc_f;
    logic [1:0]         dac_f;
    logic               dm_en;
    logic [1:0]         dm_sel;
    logic               se;
    logic [7:0]         dosr;
    logic               zl;
    logic               zr;
  } cmc_core_s;

  cmc_core_s q, d;

  logic       link_enable;
  logic       word_toggle;
  logic [6:0] word_index;
  logic [7:0] word_data;
  logic       zero_l;
  logic       zero_r;
  logic       tog_new;
  logic       sel_rise;
  logic       pin_mode;
  logic       commit;
  logic [6:0] commit_idx;
  logic [7:0] commit_data;
  logic       deemph_pin;
  logic       iface_format_pin;
  logic       iface_role_pin;
  logic       zero_flag_grouping;
  logic       zero_flag_polarity;
  logic       both_zero;

  function automatic cmc_pkg::cmc_mode_e strap_decode(input logic [1:0] s);
    cmc_pkg::cmc_mode_e m;
    case (s)
      cmc_pkg::STRAP_TIED_LOW:  m = cmc_pkg::MODE_TWO_WIRE;
      cmc_pkg::STRAP_PULLDOWN:  m = cmc_pkg::MODE_PIN_DIFF;
      cmc_pkg::STRAP_PULLUP:    m = cmc_pkg::MODE_PIN_SE;
      cmc_pkg::STRAP_TIED_HIGH: m = cmc_pkg::MODE_THREE_WIRE;
      default:                  m = cmc_pkg::MODE_TWO_WIRE;
    endcase
    return m;
  endfunction

  // serial port lives on the host's clock
  assign link_enable = q.captured && q.mode == cmc_pkg::MODE_THREE_WIRE;

  cmc_spi_shift u_shift (
    .ctrl_serial_clock   (ctrl_serial_clock),
    .ctrl_select_n       (ctrl_select_n),
    .ctrl_serial_data_in (ctrl_serial_data_in),
    .reset               (reset),
    .link_enable         (link_enable),
    .word_toggle         (word_toggle),
    .word_index          (word_index),
    .word_data           (word_data)
  );

  cmc_zero_detect u_zero_l (
    .core_clk      (core_clk),
    .reset         (reset),
    .sample_strobe (dac_sample_strobe & ~dac_sample_right),
    .sample_zero   (dac_sample_zero),
    .zero_detected (zero_l)
  );

  cmc_zero_detect u_zero_r (
    .core_clk      (core_clk),
    .reset         (reset),
    .sample_strobe (dac_sample_strobe & dac_sample_right),
    .sample_zero   (dac_sample_zero),
    .zero_detected (zero_r)
  );

  // pin roles depend on the captured mode
  assign deemph_pin       = q.pin_s[0];
  assign iface_format_pin = q.pin_s[1];
  assign iface_role_pin   = q.pin_s[2];
  assign pin_mode = q.captured &&
                    (q.mode == cmc_pkg::MODE_PIN_DIFF || q.mode == cmc_pkg::MODE_PIN_SE);

  // word index and data are stable for a whole byte time once the toggle lands
  assign tog_new  = q.tog_s ^ q.tog_seen;
  // select edge delayed past the toggle path so the last byte is never overtaken
  assign sel_rise = q.sel_dly[1] & ~q.sel_dly[2];

  assign zero_flag_grouping = q.regs[3][cmc_pkg::ZERO_GROUP_BIT];
  assign zero_flag_polarity = q.regs[3][cmc_pkg::ZERO_POL_BIT];
  assign both_zero          = zero_l & zero_r;

  always_comb begin
    d = q;
    commit      = 1'b0;
    commit_idx  = q.pend_idx;
    commit_data = q.pend_data;

    // two-stage synchronisers on all pins and the link toggle
    d.strap_m  = mode_strap;
    d.strap_s  = q.strap_m;
    d.pin_m    = {ctrl_select_n, ctrl_serial_clock, ctrl_serial_data_in};
    d.pin_s    = q.pin_m;
    d.tog_m    = word_toggle;
    d.tog_s    = q.tog_m;
    d.sel_dly  = {q.sel_dly[1:0], q.pin_s[2]};

    // strap caught once after release, then frozen
    if (!q.captured) begin
      if (q.settle == cmc_pkg::STRAP_SETTLE) begin
        d.captured = 1'b1;
        d.mode     = strap_decode(q.strap_s);
      end else begin
        d.settle = q.settle + 2'h1;
      end
    end

    // pending word commits on the next word or on frame close
    if (tog_new) begin
      d.tog_seen  = q.tog_s;
      commit      = q.pend_v;
      d.pend_v    = 1'b1;
      d.pend_idx  = word_index;
      d.pend_data = word_data;
    end else if (q.close) begin
      commit   = q.pend_v;
      d.pend_v = 1'b0;
      d.close  = 1'b0;
    end
    // no complete word means nothing is pending to write
    if (sel_rise && link_enable) begin
      d.close = 1'b1;
    end

    if (commit && link_enable) begin
      case (commit_idx)
        cmc_pkg::REG_SYS_IDX:  d.regs[0] = commit_data;
        cmc_pkg::REG_ADC_IDX:  d.regs[1] = commit_data;
        cmc_pkg::REG_DAC_IDX:  d.regs[2] = commit_data;
        cmc_pkg::REG_ZERO_IDX: d.regs[3] = commit_data;
        default:               d.regs    = q.regs;
      endcase
    end

    if (pin_mode) begin
      d.adc_m  = iface_role_pin;
      d.dac_m  = 1'b0;
      d.adc_f  = iface_format_pin ? cmc_pkg::FMT_LJ_24 : cmc_pkg::FMT_I2S_24;
      d.dac_f  = iface_format_pin ? cmc_pkg::FMT_LJ_24 : cmc_pkg::FMT_I2S_24;
      d.dm_en  = deemph_pin;
      d.dm_sel = cmc_pkg::DEEMPH_44K1;
      d.se     = q.mode == cmc_pkg::MODE_PIN_SE;
    end else begin
      d.adc_m  = q.regs[1][cmc_pkg::IF_MASTER_BIT];
      d.dac_m  = q.regs[2][cmc_pkg::IF_MASTER_BIT];
      d.adc_f  = q.regs[1][cmc_pkg::IF_FMT_LSB +: 2];
      d.dac_f  = q.regs[2][cmc_pkg::IF_FMT_LSB +: 2];
      d.dm_en  = q.regs[2][cmc_pkg::DAC_DEEMPH_BIT];
      d.dm_sel = q.regs[2][cmc_pkg::DAC_DSEL_LSB +: 2];
      d.se     = q.regs[0][cmc_pkg::SYS_SE_BIT];
    end

    // dac rate from clock ratio, doubled on request
    case (dac_ratio_class)
      cmc_pkg::RATIO_HIGH: d.dosr = cmc_pkg::DAC_OSR_HIGH;
      cmc_pkg::RATIO_MID:  d.dosr = cmc_pkg::DAC_OSR_MID;
      default:             d.dosr = cmc_pkg::DAC_OSR_LOW;
    endcase
    if (!pin_mode && q.regs[0][cmc_pkg::SYS_DBL_BIT]) begin
      d.dosr = {d.dosr[6:0], 1'b0};
    end

    // grouping then polarity
    d.zl = (zero_flag_grouping ? both_zero : zero_l) ^ zero_flag_polarity;
    d.zr = (zero_flag_grouping ? both_zero : zero_r) ^ zero_flag_polarity;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // select idles high, so a zero here would fake a select rise after reset
      q <= '{strap_m: 2'h0, strap_s: 2'h0, pin_m: 3'h4, pin_s: 3'h4,
             tog_m: 1'b0, tog_s: 1'b0, tog_seen: 1'b0, sel_dly: 3'h7,
             settle: 2'h0, captured: 1'b0, mode: cmc_pkg::MODE_TWO_WIRE,
             close: 1'b0, pend_v: 1'b0, pend_idx: 7'h00, pend_data: 8'h00,
             regs: {cmc_pkg::REG_ZERO_RST, cmc_pkg::REG_DAC_RST,
                    cmc_pkg::REG_ADC_RST, cmc_pkg::REG_SYS_RST},
             adc_m: 1'b0, dac_m: 1'b0, adc_f: 2'h0, dac_f: 2'h0,
             dm_en: 1'b0, dm_sel: 2'h0, se: 1'b0, dosr: 8'h00,
             zl: 1'b0, zr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ctrl_mode        = q.mode;
  assign mode_captured    = q.captured;
  // two-wire pins only reach their block in two-wire mode
  assign twowire_data     = q.captured && q.mode == cmc_pkg::MODE_TWO_WIRE && q.pin_s[0];
  assign twowire_clock    = q.captured && q.mode == cmc_pkg::MODE_TWO_WIRE && q.pin_s[1];
  assign twowire_addr_sel = q.captured && q.mode == cmc_pkg::MODE_TWO_WIRE && q.pin_s[2];
  assign adc_master       = q.adc_m;
  assign dac_master       = q.dac_m;
  assign adc_format       = q.adc_f;
  assign dac_format       = q.dac_f;
  assign deemph_en        = q.dm_en;
  assign deemph_sel       = q.dm_sel;
  assign dac_single_ended = q.se;
  assign adc_osr          = cmc_pkg::ADC_OSR;
  assign dac_osr          = q.dosr;
  assign left_zero_flag   = q.zl;
  assign right_zero_flag  = q.zr;

  strap_frozen_a: assert property (@(posedge core_clk) disable iff (reset)
    $past(q.captured) |-> $stable(q.mode) && $stable(q.captured))
    else $error("captured mode changed after capture");

  strap_decode_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(q.captured) |-> q.mode == strap_decode($past(q.strap_s)))
    else $error("strap decoded wrongly");

  pin_role_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_mode |=> adc_master == $past(iface_role_pin) && !dac_master)
    else $error("pin mode interface role wrong");

  pin_format_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_mode |=> adc_format == ($past(iface_format_pin) ? cmc_pkg::FMT_LJ_24
                                : cmc_pkg::FMT_I2S_24) && dac_format == adc_format)
    else $error("pin mode format wrong");

  pin_deemph_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_mode |=> deemph_en == $past(deemph_pin) && deemph_sel == cmc_pkg::DEEMPH_44K1)
    else $error("pin mode de-emphasis wrong");

  reg_commit_a: assert property (@(posedge core_clk) disable iff (reset)
    commit && link_enable && commit_idx == cmc_pkg::REG_ADC_IDX
      |=> q.regs[1] == $past(commit_data) ##2 adc_master == q.regs[1][0])
    else $error("register commit did not reach output");

  short_frame_a: assert property (@(posedge core_clk) disable iff (reset)
    q.close && !q.pend_v && !tog_new |=> $stable(q.regs))
    else $error("registers changed without complete word");

  close_commit_a: assert property (@(posedge core_clk) disable iff (reset)
    sel_rise && link_enable |-> ##[1:3] !q.pend_v || tog_new)
    else $error("pending word not committed at frame end");

  zero_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    !zero_flag_grouping && !zero_flag_polarity |=> left_zero_flag == $past(zero_l))
    else $error("zero flag not following own channel");

  zero_group_a: assert property (@(posedge core_clk) disable iff (reset)
    zero_flag_grouping |=> left_zero_flag == right_zero_flag &&
                           left_zero_flag == ($past(both_zero) ^ $past(zero_flag_polarity)))
    else $error("grouped or inverted zero flag wrong");

  single_end_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_mode |=> dac_single_ended == ($past(q.mode) == cmc_pkg::MODE_PIN_SE))
    else $error("output configuration not from strap");

  dac_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_mode && dac_ratio_class == cmc_pkg::RATIO_MID |=> dac_osr == cmc_pkg::DAC_OSR_MID)
    else $error("dac oversampling wrong");

  dac_base_a: assert property (@(posedge core_clk) disable iff (reset)
    !pin_mode && !q.regs[0][cmc_pkg::SYS_DBL_BIT] && dac_ratio_class == cmc_pkg::RATIO_HIGH
      |=> dac_osr == cmc_pkg::DAC_OSR_HIGH)
    else $error("dac base oversampling wrong");

  zero_set_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(zero_l) |-> $past(dac_sample_strobe && !dac_sample_right && dac_sample_zero))
    else $error("left zero flag set without a zero sample");

  zero_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    dac_sample_strobe && !dac_sample_right && !dac_sample_zero |=> !zero_l)
    else $error("left zero flag kept after non-zero sample");

endmodule // cmc_ctrl_port

// [verif/cmc_host_model.sv]
module cmc_host_model (
  // host side of the shared control pins
  output logic ctrl_serial_clock,
  output logic ctrl_serial_data_in,
  output logic ctrl_select_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ctrl_serial_clock   = 1'b0;
    ctrl_serial_data_in = 1'b0;
    ctrl_select_n       = 1'b1;
  end

  // static levels for the pin-driven personalities
  task automatic set_pins(input logic role, input logic fmt, input logic demph);
    ctrl_select_n       = role;
    ctrl_serial_clock   = fmt;
    ctrl_serial_data_in = demph;
  endtask

  // clock stands low outside frames; byte gaps let the slow core commit
  task automatic send_frame(input logic [7:0] bytes [$], input int nbits);
    #40 ctrl_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      ctrl_serial_data_in = bytes[i / 8][7 - i % 8];
      #16 ctrl_serial_clock = 1'b1;
      #16 ctrl_serial_clock = 1'b0;
      if (i % 8 == 7) #400;
    end
    #20 ctrl_select_n = 1'b1;
    // released line must not keep its last value
    ctrl_serial_data_in = ~ctrl_serial_data_in;
    #300;
  endtask
endmodule // cmc_host_model

// [verif/test_codec_mode_control_port.sv]
module test_codec_mode_control_port;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

  logic               core_clk = 1'b0;
  logic               reset = 1'b1;
  logic [1:0]         mode_strap = 2'h3;
  logic               dac_sample_strobe = 1'b0, dac_sample_right = 1'b0;
  logic               dac_sample_zero = 1'b0;
  logic [1:0]         dac_ratio_class = 2'h0;
  logic               ctrl_serial_clock, ctrl_serial_data_in, ctrl_select_n;
  cmc_pkg::cmc_mode_e ctrl_mode;
  logic               mode_captured, twowire_data, twowire_clock, twowire_addr_sel;
  logic               adc_master, dac_master, deemph_en, dac_single_ended;
  logic               left_zero_flag, right_zero_flag;
  logic [1:0]         adc_format, dac_format, deemph_sel;
  logic [7:0]         adc_osr, dac_osr;
  int                 checks = 0, miscompares = 0, seed = 50510;
  logic               r, f, d, pin;
  logic [7:0]         v [3];

  always #50 core_clk = ~core_clk;

  cmc_host_model u_cmc_host_model (.ctrl_serial_clock(ctrl_serial_clock),
    .ctrl_serial_data_in(ctrl_serial_data_in), .ctrl_select_n(ctrl_select_n));

  cmc_ctrl_port u_cmc_ctrl_port (.core_clk(core_clk), .reset(reset),
    .mode_strap(mode_strap), .ctrl_serial_clock(ctrl_serial_clock),
    .ctrl_serial_data_in(ctrl_serial_data_in), .ctrl_select_n(ctrl_select_n),
    .dac_sample_strobe(dac_sample_strobe), .dac_sample_right(dac_sample_right),
    .dac_sample_zero(dac_sample_zero), .dac_ratio_class(dac_ratio_class),
    .ctrl_mode(ctrl_mode), .mode_captured(mode_captured), .twowire_data(twowire_data),
    .twowire_clock(twowire_clock), .twowire_addr_sel(twowire_addr_sel),
    .adc_master(adc_master), .dac_master(dac_master), .adc_format(adc_format),
    .dac_format(dac_format), .deemph_en(deemph_en), .deemph_sel(deemph_sel),
    .dac_single_ended(dac_single_ended), .adc_osr(adc_osr), .dac_osr(dac_osr),
    .left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag));

  function automatic logic [7:0] exp_osr(input logic [1:0] rc, input logic dbl);
    logic [7:0] b;
    b = (rc == cmc_pkg::RATIO_HIGH) ? cmc_pkg::DAC_OSR_HIGH :
        (rc == cmc_pkg::RATIO_MID) ? cmc_pkg::DAC_OSR_MID : cmc_pkg::DAC_OSR_LOW;
    return dbl ? {b[6:0], 1'b0} : b;
  endfunction

  function automatic logic zf(input logic own, input logic both, input logic [7:0] z);
    return (z[cmc_pkg::ZERO_GROUP_BIT] ? both : own) ^ z[cmc_pkg::ZERO_POL_BIT];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic done(input string t);
    $display("test %s done: checks %0d miscompares %0d", t, checks, miscompares);
  endtask

  task automatic do_reset(input logic [1:0] s);
    mode_strap = s;
    u_cmc_host_model.set_pins(1'b1, 1'b0, 1'b0);
    reset = 1'b1;
    cyc(5);
    reset = 1'b0;
    cyc(6);
  endtask

  // cut drops that many trailing clocks to make short frames
  task automatic wr(input logic [6:0] idx, input logic [7:0] dq [$], input int cut);
    logic [7:0] q [$];
    q = dq;
    q.push_front({1'b0, idx});
    u_cmc_host_model.send_frame(q, 8 * q.size() - cut);
    cyc(12);
  endtask

  task automatic smp(input logic rt, input logic z);
    dac_sample_strobe = 1'b1;
    dac_sample_right = rt;
    dac_sample_zero = z;
    cyc(1);
    dac_sample_strobe = 1'b0;
    cyc(1);
  endtask

  task automatic chk_regs(input logic [7:0] sy, input logic [7:0] ad, input logic [7:0] da);
    `CHK("adc_master", ad[cmc_pkg::IF_MASTER_BIT], adc_master)
    `CHK("adc_format", ad[2:1], adc_format)
    `CHK("dac_master", da[cmc_pkg::IF_MASTER_BIT], dac_master)
    `CHK("dac_format", da[2:1], dac_format)
    `CHK("deemph_en", da[cmc_pkg::DAC_DEEMPH_BIT], deemph_en)
    `CHK("deemph_sel", da[5:4], deemph_sel)
    `CHK("single_ended", sy[cmc_pkg::SYS_SE_BIT], dac_single_ended)
    dac_ratio_class = 2'($random(seed));
    cyc(3);
    `CHK("dac_osr", exp_osr(dac_ratio_class, sy[1]), dac_osr)
  endtask

  task automatic zero_case(input logic [7:0] z);
    wr(cmc_pkg::REG_ZERO_IDX, {z}, 0);
    smp(1'b0, 1'b0);
    smp(1'b1, 1'b0);
    repeat (1023) begin
      smp(1'b0, 1'b1);
      smp(1'b1, 1'b1);
    end
    cyc(2);
    `CHK("left_flag", zf(1'b0, 1'b0, z), left_zero_flag)
    `CHK("right_flag", zf(1'b0, 1'b0, z), right_zero_flag)
    smp(1'b0, 1'b1);
    cyc(2);
    `CHK("left_flag", zf(1'b1, 1'b0, z), left_zero_flag)
    `CHK("right_flag", zf(1'b0, 1'b0, z), right_zero_flag)
    smp(1'b1, 1'b1);
    cyc(2);
    `CHK("left_flag", zf(1'b1, 1'b1, z), left_zero_flag)
    `CHK("right_flag", zf(1'b1, 1'b1, z), right_zero_flag)
    smp(1'b1, 1'b0);
    cyc(2);
    `CHK("left_flag", zf(1'b1, 1'b0, z), left_zero_flag)
    `CHK("right_flag", zf(1'b0, 1'b0, z), right_zero_flag)
  endtask

  // about 17k cycles expected; 30k cycles is a hang
  initial begin
    #3000000;
    miscompares++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      r = 1'($random(seed));
      f = 1'($random(seed));
      d = 1'($random(seed));
      pin = (s == 1) || (s == 2);
      if (s != 3) u_cmc_host_model.set_pins(r, f, d);
      dac_ratio_class = (s == 1) ? cmc_pkg::RATIO_MID : 2'($random(seed));
      cyc(5);
      `CHK("ctrl_mode", cmc_pkg::cmc_mode_e'(s), ctrl_mode)
      `CHK("captured", 1'b1, mode_captured)
      `CHK("tw_data", (s == 0) & d, twowire_data)
      `CHK("tw_clock", (s == 0) & f, twowire_clock)
      `CHK("tw_addr", (s == 0) & r, twowire_addr_sel)
      `CHK("adc_master", pin & r, adc_master)
      `CHK("dac_master", 1'b0, dac_master)
      `CHK("adc_format", (pin & f) ? cmc_pkg::FMT_LJ_24 : cmc_pkg::FMT_I2S_24, adc_format)
      `CHK("dac_format", (pin & f) ? cmc_pkg::FMT_LJ_24 : cmc_pkg::FMT_I2S_24, dac_format)
      `CHK("deemph_en", pin & d, deemph_en)
      `CHK("deemph_sel", pin ? cmc_pkg::DEEMPH_44K1 : 2'h0, deemph_sel)
      `CHK("single_ended", s == 2, dac_single_ended)
      `CHK("adc_osr", cmc_pkg::ADC_OSR, adc_osr)
      `CHK("dac_osr", exp_osr(dac_ratio_class, 1'b0), dac_osr)
      mode_strap = ~mode_strap;
      cyc(5);
      `CHK("ctrl_mode", cmc_pkg::cmc_mode_e'(s), ctrl_mode)
    end
    done("strap");
    do_reset(2'h3);
    foreach (v[i]) v[i] = 8'($random(seed));
    wr(cmc_pkg::REG_DAC_IDX, {v[2]}, 0);
    chk_regs(8'h00, 8'h00, v[2]);
    wr(cmc_pkg::REG_ADC_IDX, {v[1]}, 1);
    chk_regs(8'h00, 8'h00, v[2]);
    // burst with a partial trailing byte aimed at the flag register
    wr(cmc_pkg::REG_SYS_IDX, {v[0], v[1], v[2], 8'hFF}, 3);
    chk_regs(v[0], v[1], v[2]);
    `CHK("left_flag", 1'b0, left_zero_flag)
    done("serial");
    for (int k = 0; k < 4; k++) zero_case(8'(k));
    done("zero");
    give_verdict();
  end
endmodule // test_codec_mode_control_port
